// ==== hw/vr_ctrl_pkg.sv ====
// Purpose: Shared constants and types for the regulator control core.
// Assumes: Reference voltages are carried in units of 0.1 mV.
// Notes: Codes and counts below are the hardware values.
package vr_ctrl_pkg;
    localparam int REF_W = 15;
    localparam logic [14:0] REF_HI_BASE = 15'h3c8c;
    localparam logic [14:0] REF_HI_STEP = 15'h00fa;
    localparam logic [14:0] REF_LO_BASE = 15'h1dc9;
    localparam logic [14:0] REF_LO_STEP = 15'h007d;
    localparam logic [14:0] REF_OFF = 15'h0000;
    localparam logic [14:0] FIX_V0 = 15'h36b0;
    localparam logic [14:0] FIX_V1 = 15'h2ee0;
    localparam logic [14:0] FIX_V2 = 15'h2710;
    localparam logic [14:0] FIX_V3 = 15'h1f40;
    localparam logic [14:0] META_V0 = 15'h2af8;
    localparam logic [14:0] META_V1 = 15'h2710;
    localparam logic [14:0] META_V2 = 15'h2328;
    localparam logic [14:0] META_V3 = 15'h1f40;
    localparam logic [2:0] PH_MIN = 3'h2;
    localparam logic [2:0] PH_MAX = 3'h4;
    localparam logic [2:0] PH_PSI = 3'h1;
    localparam logic [14:0] SS_STEP = 15'h0001;
    localparam logic [1:0] NB_SHIFT_DEF = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PARALLEL = 3'b010,
        ST_SERIAL = 3'b100
    } mode_t;

    typedef struct packed {
        logic high_side;
        logic low_side;
    } gate_t;

    typedef struct packed {
        logic [14:0] voltage_offset;
        logic [7:0] freq_setting;
        logic [7:0] ovp_setting;
        logic dpm_enable;
        logic [1:0] load_level;
    } pm_cfg_t;
endpackage

// ==== hw/vr_ctrl_core.sv ====
// Purpose: Mode detection, parallel code decode and phase control of a CPU regulator.
// Assumes: All inputs synchronous to clk_sys; enable acts as start and reset.
// Notes: Serial transaction decoding lives outside; its results arrive as ports.
`timescale 1ns/1ns
module vr_ctrl_core #(
    parameter int CORE_PHASES = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [5:0] voltage_id_lines,
    input wire logic power_ok_input,
    input wire logic fix_mode,
    input wire logic serial_cmd_valid,
    input wire logic serial_cmd_core,
    input wire logic serial_cmd_nb,
    input wire logic [14:0] serial_cmd_ref,
    input wire logic power_saving_flag_n,
    input wire vr_ctrl_pkg::pm_cfg_t pm_cfg,
    output vr_ctrl_pkg::mode_t mode,
    output logic parallel_id_mode,
    output logic serial_id_mode,
    output logic [14:0] core_ref,
    output logic [14:0] nb_ref,
    output logic nb_enable,
    output vr_ctrl_pkg::gate_t nb_gate,
    output logic [2:0] core_phases_active,
    output logic [1:0] nb_phase_slot,
    output logic [7:0] freq_setting,
    output logic [7:0] ovp_setting
);
    import vr_ctrl_pkg::*;

    if (CORE_PHASES < 2 || CORE_PHASES > 4) begin : g_phase_check
        $error("CORE_PHASES must be 2 to 4.");
    end

    ////////////////////////////////////////////////////////////////////
    // Enable edge and mode latch.
    logic enable_d;
    logic [14:0] target_core;
    logic [14:0] target_nb;
    logic [14:0] decoded;
    logic [14:0] meta_ref;
    logic [14:0] fix_ref;
    logic [14:0] soft_core;
    logic [14:0] soft_nb;
    logic [14:0] op_core;
    logic [14:0] op_nb;
    logic [2:0] next_phases;
    logic [2:0] cfg_phases;
    logic [1:0] serial_pair;
    logic meta_loaded;

    assign serial_pair = voltage_id_lines[3:2];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            enable_d <= 1'b0;
        end else begin
            enable_d <= enable;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !enable) begin
            mode <= ST_IDLE;
            parallel_id_mode <= 1'b0;
            serial_id_mode <= 1'b0;
        end else if (!enable_d) begin
            mode <= voltage_id_lines[1] ? ST_PARALLEL : ST_SERIAL;
            parallel_id_mode <= voltage_id_lines[1];
            serial_id_mode <= !voltage_id_lines[1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reference decode.
    always_comb begin
        decoded = REF_OFF;
        if (!voltage_id_lines[5]) begin
            decoded = REF_HI_BASE - 15'(voltage_id_lines[4:0] * REF_HI_STEP);
        end else begin
            decoded = REF_LO_BASE - 15'(voltage_id_lines[4:0] * REF_LO_STEP);
        end
    end

    always_comb begin
        fix_ref = FIX_V3;
        meta_ref = META_V3;
        unique case (serial_pair)
            2'h0: begin
                fix_ref = FIX_V0;
                meta_ref = META_V0;
            end
            2'h1: begin
                fix_ref = FIX_V1;
                meta_ref = META_V1;
            end
            2'h2: begin
                fix_ref = FIX_V2;
                meta_ref = META_V2;
            end
            2'h3: begin
                fix_ref = FIX_V3;
                meta_ref = META_V3;
            end
        endcase
    end

    // The strap value is taken once per serial start, whatever power-ok shows then.
    always_ff @(posedge clk_sys) begin
        if (!rst_n || mode != ST_SERIAL) begin
            meta_loaded <= 1'b0;
        end else begin
            meta_loaded <= 1'b1;
        end
    end

    // Serial operating targets: start at the strap value, then follow the fixed straps in fix mode, else commands while power-ok is high.
    always_ff @(posedge clk_sys) begin
        if (!rst_n || mode != ST_SERIAL) begin
            op_core <= REF_OFF;
            op_nb <= REF_OFF;
        end else if (!meta_loaded) begin
            op_core <= meta_ref;
            op_nb <= meta_ref;
        end else if (fix_mode) begin
            op_core <= fix_ref;
            op_nb <= fix_ref;
        end else if (power_ok_input && serial_cmd_valid) begin
            if (serial_cmd_core) begin
                op_core <= serial_cmd_ref;
            end
            if (serial_cmd_nb) begin
                op_nb <= serial_cmd_ref;
            end
        end
    end

    always_comb begin
        target_core = REF_OFF;
        target_nb = REF_OFF;
        unique case (mode)
            ST_IDLE: begin
                target_core = REF_OFF;
            end
            ST_PARALLEL: begin
                target_core = decoded;
                target_nb = REF_OFF;
            end
            ST_SERIAL: begin
                target_core = op_core + pm_cfg.voltage_offset;
                target_nb = op_nb + pm_cfg.voltage_offset;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Soft start ramps up toward the target one step per cycle and drops to a lower target at once.
    always_ff @(posedge clk_sys) begin
        if (!rst_n || mode == ST_IDLE) begin
            soft_core <= REF_OFF;
        end else if (soft_core < target_core) begin
            soft_core <= soft_core + SS_STEP;
        end else begin
            soft_core <= target_core;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || mode != ST_SERIAL) begin
            soft_nb <= REF_OFF;
        end else if (soft_nb < target_nb) begin
            soft_nb <= soft_nb + SS_STEP;
        end else begin
            soft_nb <= target_nb;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            core_ref <= REF_OFF;
            nb_ref <= REF_OFF;
            nb_enable <= 1'b0;
            nb_gate <= '0;
        end else begin
            core_ref <= soft_core;
            nb_ref <= soft_nb;
            nb_enable <= (mode == ST_SERIAL) && (soft_nb != REF_OFF);
            nb_gate <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Phase management.
    assign cfg_phases = 3'(CORE_PHASES);

    always_comb begin
        next_phases = cfg_phases;
        if (pm_cfg.dpm_enable) begin
            next_phases = PH_MIN + 3'(pm_cfg.load_level);
            if (next_phases > cfg_phases) begin
                next_phases = cfg_phases;
            end
        end
        if (mode == ST_SERIAL && !power_saving_flag_n) begin
            next_phases = PH_PSI;
        end
        if (mode == ST_IDLE) begin
            next_phases = 3'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            core_phases_active <= 3'h0;
            nb_phase_slot <= 2'h0;
            freq_setting <= 8'h00;
            ovp_setting <= 8'h00;
        end else begin
            core_phases_active <= next_phases;
            nb_phase_slot <= nb_enable ? 2'(next_phases >> 1) : 2'h0;
            freq_setting <= pm_cfg.freq_setting;
            ovp_setting <= pm_cfg.ovp_setting;
        end
    end
endmodule

// ==== sim/vr_ctrl_properties.sv ====
// Purpose: Port-level checks for the regulator control core.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Bound to every core instance.
`timescale 1ns/1ns
module vr_ctrl_checker
    import vr_ctrl_pkg::*;
#(
    parameter int CORE_PHASES = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [5:0] voltage_id_lines,
    input wire logic power_saving_flag_n,
    input wire vr_ctrl_pkg::pm_cfg_t pm_cfg,
    input wire vr_ctrl_pkg::mode_t mode,
    input wire logic parallel_id_mode,
    input wire logic serial_id_mode,
    input wire logic [14:0] core_ref,
    input wire logic nb_enable,
    input wire vr_ctrl_pkg::gate_t nb_gate,
    input wire logic [2:0] core_phases_active,
    input wire logic [7:0] freq_setting,
    input wire logic [7:0] ovp_setting
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_par_latch: assert property (
        $rose(enable) && voltage_id_lines[1] |=> mode == ST_PARALLEL) else $error("no parallel");
    a_ser_latch: assert property (
        $rose(enable) && !voltage_id_lines[1] |=> mode == ST_SERIAL) else $error("no serial");
    a_idle_low: assert property (!enable |=> mode == ST_IDLE)
        else $error("mode not idle");
    a_nb_off: assert property (
        parallel_id_mode |-> nb_gate == 2'h0 && !nb_enable) else $error("nb active");
    a_soft_ramp: assert property (
        parallel_id_mode && $past(parallel_id_mode) && core_ref > $past(core_ref)
        |-> core_ref == $past(core_ref) + 15'h0001) else $error("ramp step");
    a_phase_max: assert property (core_phases_active <= CORE_PHASES)
        else $error("too many phases");
    a_cfg_follow: assert property ($stable(pm_cfg) [*4] |->
        freq_setting == pm_cfg.freq_setting && ovp_setting == pm_cfg.ovp_setting)
        else $error("cfg not applied");
    a_psi_one: assert property (
        (serial_id_mode && !power_saving_flag_n) [*3] |-> core_phases_active == PH_PSI)
        else $error("psi phases");
    c_par: cover property ($rose(enable) && voltage_id_lines[1]);
    c_ser: cover property ($rose(enable) && !voltage_id_lines[1]);
    c_psi: cover property (serial_id_mode && core_phases_active == PH_PSI);
endmodule
////////////////////////////////////////////////////////////
bind vr_ctrl_core vr_ctrl_checker #(.CORE_PHASES(CORE_PHASES)) chk (.*);

// ==== sim/cpu_vid_model.sv ====
// Purpose: CPU side that drives the identification lines.
// Assumes: Lines change just after the rising clock edge.
// Notes: While enable is low the type strap sits on line one.
`timescale 1ns/1ns
module cpu_vid_model (
    input wire logic clk_sys,
    input wire logic enable,
    input wire logic [5:0] code,
    input wire logic serial_cpu,
    output logic [5:0] voltage_id_lines
);
    always_ff @(posedge clk_sys) begin
        if (!enable) begin
            voltage_id_lines <= {code[5:2], ~serial_cpu, code[0]};
        end else begin
            voltage_id_lines <= code;
        end
    end
endmodule

// ==== sim/vr_ctrl_core_test.sv ====
// Purpose: Directed tests of mode detection, decode and phase control.
// Assumes: The CPU model drives the identification lines.
// Notes: Serial command ports carry one core-only command near the end.
`timescale 1ns/1ns
module vr_ctrl_core_test;
    import vr_ctrl_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic enable = 1'b0;
    logic power_ok_input = 1'b0;
    logic fix_mode = 1'b0;
    logic serial_cmd_valid = 1'b0;
    logic serial_cmd_core = 1'b0;
    logic serial_cmd_nb = 1'b0;
    logic [14:0] serial_cmd_ref = 15'h0000;
    logic power_saving_flag_n = 1'b1;
    pm_cfg_t pm_cfg = '0;
    logic [5:0] code = 6'h00;
    logic serial_cpu = 1'b0;
    logic [5:0] voltage_id_lines;
    mode_t mode;
    logic parallel_id_mode, serial_id_mode, nb_enable;
    logic [14:0] core_ref, nb_ref;
    gate_t nb_gate;
    logic [2:0] core_phases_active;
    logic [1:0] nb_phase_slot;
    logic [7:0] freq_setting, ovp_setting;
    int num_errors = 0;
    int tests_run = 0;
    vr_ctrl_core #(.CORE_PHASES(4)) DUT (.*);
    cpu_vid_model cpu (.*);
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic wait_ref(input logic [14:0] t);
        for (int i = 0; i < 16000 && !(core_ref === t && (!fix_mode || nb_ref === t)); i++) begin
            @(negedge clk_sys);
        end
    endtask
    function automatic logic [14:0] par_ref(input logic [5:0] c);
        return c[5] ? 15'(7625 - 125 * c[4:0]) : 15'(15500 - 250 * c[4:0]);
    endfunction
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        #2400000;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        settle(0);
        check("mode", 15'(mode), 15'(ST_IDLE));
        @(posedge clk_sys);
        enable <= 1'b1;
        settle(2);
        check("mode", 15'(mode), 15'(ST_PARALLEL));
        check("parallel_id_mode", 15'(parallel_id_mode), 15'h0001);
        check("nb_gate", 15'(nb_gate), 15'h0000);
        wait_ref(15'h3c8c);
        check("core_ref", core_ref, 15'h3c8c);
        for (int c = 1; c < 64; c++) begin
            @(posedge clk_sys);
            code <= 6'(c);
            power_ok_input <= c[0];
            settle(4);
            check("core_ref", core_ref, par_ref(6'(c)));
        end
        check("mode", 15'(mode), 15'(ST_PARALLEL));
        check("nb_enable", 15'(nb_enable), 15'h0000);
        for (int l = 0; l < 4; l++) begin
            @(posedge clk_sys);
            pm_cfg <= '{15'h0000, 8'(8'h40 + l), 8'(8'h80 + l), 1'b1, 2'(l)};
            settle(4);
            check("phases", 15'(core_phases_active), 15'(l < 3 ? 2 + l : 4));
            check("freq", 15'(freq_setting), 15'(8'h40 + l));
            check("ovp", 15'(ovp_setting), 15'(8'h80 + l));
        end
        @(posedge clk_sys);
        enable <= 1'b0;
        serial_cpu <= 1'b1;
        pm_cfg.dpm_enable <= 1'b0;
        power_ok_input <= 1'b1;
        code <= 6'h31;
        repeat (3) @(posedge clk_sys);
        enable <= 1'b1;
        settle(2);
        check("mode", 15'(mode), 15'(ST_SERIAL));
        @(posedge clk_sys);
        power_saving_flag_n <= 1'b0;
        settle(4);
        check("phases", 15'(core_phases_active), 15'h0001);
        @(posedge clk_sys);
        power_saving_flag_n <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            fix_mode <= 1'b1;
            code <= 6'(6'h31 | (k << 2));
            wait_ref(15'(15'h36b0 - 15'h07d0 * k));
            check("core_ref", core_ref, 15'(15'h36b0 - 15'h07d0 * k));
            check("nb_ref", nb_ref, 15'(15'h36b0 - 15'h07d0 * k));
        end
        check("serial_id_mode", 15'(serial_id_mode), 15'h0001);
        check("nb_enable", 15'(nb_enable), 15'h0001);
        check("nb_phase_slot", 15'(nb_phase_slot), 15'h0002);
        @(posedge clk_sys);
        pm_cfg.voltage_offset <= 15'h0010;
        serial_cmd_valid <= 1'b1;
        serial_cmd_core <= 1'b1;
        serial_cmd_ref <= 15'h0100;
        settle(20);
        check("core_ref", core_ref, 15'h1f50);
        @(posedge clk_sys);
        fix_mode <= 1'b0;
        settle(4);
        check("core_ref", core_ref, 15'h0110);
        check("nb_ref", nb_ref, 15'h1f50);
        stop_test();
    end
endmodule
